// File: rtl/fepcs_pkg.sv
// Types shared by the fast ethernet coding path and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package fepcs_pkg;

    typedef enum logic [1:0] {
        FEPCS_LVL_ZERO = 2'b00,
        FEPCS_LVL_PLUS = 2'b01,
        FEPCS_LVL_MINUS = 2'b11
    } fepcs_level_e;

    typedef enum logic [2:0] {
        FEPCS_TX_IDLE = 3'b000,
        FEPCS_TX_J = 3'b001,
        FEPCS_TX_K = 3'b010,
        FEPCS_TX_DATA = 3'b011,
        FEPCS_TX_T = 3'b100,
        FEPCS_TX_R = 3'b101
    } fepcs_tx_state_e;

    typedef enum logic [0:0] {
        FEPCS_RX_HUNT = 1'b0,
        FEPCS_RX_DATA = 1'b1
    } fepcs_rx_state_e;

    typedef struct packed {
        fepcs_level_e level;
        logic nrzi;
    } fepcs_line_s;

    typedef struct packed {
        logic dv;
        logic er;
        logic [3:0] data;
    } fepcs_mii_rx_s;

    typedef struct packed {
        logic tick42;
        logic tick25;
        logic tick10;
    } fepcs_ticks_s;

endpackage

// File: rtl/fepcs_regs.svh
// Timing, code groups and reset values of the fast ethernet coding path.
// Assumes one core_clk cycle with clkEn high is one 125 MHz line bit time.
`ifndef FEPCS_REGS_SVH
`define FEPCS_REGS_SVH

`define FEPCS_BIT_RATE_MHZ 125
`define FEPCS_REF_RATE_MHZ 25
`define FEPCS_BITS_PER_REF (`FEPCS_BIT_RATE_MHZ / `FEPCS_REF_RATE_MHZ)
`define FEPCS_SYM_BITS 5
`define FEPCS_TICK42_BITS 3
`define FEPCS_TICK10_BITS 25
`define FEPCS_TICK10_HALF 12
`define FEPCS_SCR_SEED 11'h7FF
`define FEPCS_SCR_TAP_A 8
`define FEPCS_SCR_TAP_B 10
`define FEPCS_FAULT_ONES 84
`define FEPCS_RUN_LIMIT 32
`define FEPCS_DESCR_LOCK_RUN 60
`define FEPCS_CODE_I 5'h1F
`define FEPCS_CODE_J 5'h18
`define FEPCS_CODE_K 5'h11
`define FEPCS_CODE_T 5'h0D
`define FEPCS_CODE_R 5'h07
`define FEPCS_CODE_H 5'h04

`endif

// File: rtl/fepcs_tx_fx.sv
// Line coding datapath of one 10/100 port: 4B/5B, scrambler, NRZI, MLT3, fiber mode.
// Assumes clkEn marks each 125 MHz bit time and all inputs are synchronous to core_clk.
//
// How it works
// - MII nibbles are shifted out one bit per 125 MHz bit time.
// - Copper transmit encodes nibbles into 4B/5B groups, then scrambles them.
// - Scrambled bits become NRZI, then drive a three-level MLT3 line level.
// - Receive tracks NRZI transitions as bit clock and converts NRZI back to NRZ.
// - Received NRZ is descrambled first, then 4B/5B groups are decoded.
// - Decoded groups are delivered to the MAC as MII receive nibbles.
// - Transmit scrambler is an 11-bit linear feedback shift register.
// - Sequence repeats every 2047 bits; receiver uses the identical sequence.
// - Fiber mode bypasses scrambling and MLT3 in both directions.
// - Fiber mode switches auto-negotiation off for the port.
// - Only ports 4 and 5 enter fiber mode, when the mode sense is high.
// - High signal detect means signal present, low means no signal.
// - Timing ticks of 42, 25 and 10 MHz count bit times; only the 25 MHz tick snaps to the 25 MHz reference.
// - Low reset input holds the block in reset.
// - Fiber without signal sends 84 ones and a zero while idle, if enabled.
`include "fepcs_regs.svh"

module fepcs_tx_fx #(
    parameter int PORT_NUM = 4
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rstN,
    input wire logic clkEn,
    input wire logic referenceClockIn,
    // MII transmit
    input wire logic txEn,
    input wire logic txEr,
    input wire logic [3:0] txData,
    output logic txReady,
    // MII receive
    output fepcs_pkg::fepcs_mii_rx_s rxMii,
    output logic rxValid,
    // Line
    output fepcs_pkg::fepcs_line_s txLine,
    input wire fepcs_pkg::fepcs_line_s rxLine,
    // Fiber and mode
    input wire logic fiberModeSense,
    input wire logic fiberSignalDetect,
    input wire logic farEndFaultEn,
    output logic fiberMode,
    output logic autoNegEnable,
    output logic rxLocked,
    // Timing
    output fepcs_pkg::fepcs_ticks_s clkTicks,
    output logic refLocked
);

    generate
        if (PORT_NUM < 1 || PORT_NUM > 5)
        begin : g_bad_port
            $error("PORT_NUM must lie in 1..5");
        end
    endgenerate

    localparam bit FIBER_CAPABLE = (PORT_NUM == 4) || (PORT_NUM == 5);

    function automatic logic [4:0] enc4b5b(input logic [3:0] n);
        logic [4:0] c;
        c = `FEPCS_CODE_H;
        unique case (n)
            4'h0: c = 5'h1E;
            4'h1: c = 5'h09;
            4'h2: c = 5'h14;
            4'h3: c = 5'h15;
            4'h4: c = 5'h0A;
            4'h5: c = 5'h0B;
            4'h6: c = 5'h0E;
            4'h7: c = 5'h0F;
            4'h8: c = 5'h12;
            4'h9: c = 5'h13;
            4'hA: c = 5'h16;
            4'hB: c = 5'h17;
            4'hC: c = 5'h1A;
            4'hD: c = 5'h1B;
            4'hE: c = 5'h1C;
            4'hF: c = 5'h1D;
        endcase
        return c;
    endfunction

    // Returns {valid, nibble}; reverse lookup of the encoder
    function automatic logic [4:0] dec5b4b(input logic [4:0] c);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++)
        begin
            if (enc4b5b(4'(i)) == c)
                r = {1'b1, 4'(i)};
        end
        return r;
    endfunction

    function automatic logic scrKey(input logic [10:0] s);
        return s[`FEPCS_SCR_TAP_A] ^ s[`FEPCS_SCR_TAP_B];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Mode
    assign fiberMode = FIBER_CAPABLE && fiberModeSense;
    assign autoNegEnable = !fiberMode;
    logic faultActive;
    assign faultActive = fiberMode && !fiberSignalDetect && farEndFaultEn;

    ////////////////////////////////////////////////////////////////////////////
    // Timing ticks from bit times; 25 MHz phase and lock from the reference
    logic refPrev_reg, refPrev_next;
    logic [2:0] refCnt_reg, refCnt_next;
    logic refLocked_reg, refLocked_next;
    logic [2:0] cnt5_reg, cnt5_next;
    logic [1:0] cnt3_reg, cnt3_next;
    logic [4:0] cnt25_reg, cnt25_next;
    fepcs_pkg::fepcs_ticks_s ticks_reg, ticks_next;
    logic refEdge;

    always_comb
    begin
        refEdge = referenceClockIn && !refPrev_reg;
        refPrev_next = referenceClockIn;
        refCnt_next = refEdge ? 3'h1 : (refCnt_reg == 3'h7 ? refCnt_reg : refCnt_reg + 3'h1);
        refLocked_next = refEdge ? (refCnt_reg == 3'(`FEPCS_BITS_PER_REF)) : refLocked_reg;
        // Symbol phase snaps to the reference edge
        cnt5_next = (refEdge || cnt5_reg == 3'(`FEPCS_SYM_BITS - 1)) ? 3'h0 : cnt5_reg + 3'h1;
        cnt3_next = (cnt3_reg == 2'(`FEPCS_TICK42_BITS - 1)) ? 2'h0 : cnt3_reg + 2'h1;
        cnt25_next = (cnt25_reg == 5'(`FEPCS_TICK10_BITS - 1)) ? 5'h00 : cnt25_reg + 5'h01;
        // 10 MHz is 12.5 bits: spacing alternates 13 and 12
        ticks_next.tick42 = (cnt3_next == 2'h0);
        ticks_next.tick25 = (cnt5_next == 3'h0);
        ticks_next.tick10 = (cnt25_next == 5'h00) || (cnt25_next == 5'(`FEPCS_TICK10_HALF));
    end

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            refPrev_reg <= 1'b0;
            refCnt_reg <= 3'h0;
            refLocked_reg <= 1'b0;
            cnt5_reg <= 3'h0;
            cnt3_reg <= 2'h0;
            cnt25_reg <= 5'h00;
            ticks_reg <= '0;
        end
        else if (clkEn)
        begin
            refPrev_reg <= refPrev_next;
            refCnt_reg <= refCnt_next;
            refLocked_reg <= refLocked_next;
            cnt5_reg <= cnt5_next;
            cnt3_reg <= cnt3_next;
            cnt25_reg <= cnt25_next;
            ticks_reg <= ticks_next;
        end
    end

    assign clkTicks = ticks_reg;
    assign refLocked = refLocked_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Transmit
    fepcs_pkg::fepcs_tx_state_e txState_reg, txState_next;
    logic [4:0] txSym_reg, txSym_next;
    logic [2:0] txBit_reg, txBit_next;
    logic [10:0] scr_reg, scr_next;
    logic [6:0] faultCnt_reg, faultCnt_next;
    logic nrzi_reg, nrzi_next;
    logic [1:0] mlt3Phase_reg, mlt3Phase_next;
    fepcs_pkg::fepcs_line_s txLine_reg, txLine_next;
    logic symEnd, codeBit, lineBit;

    always_comb
    begin
        symEnd = (txBit_reg == 3'(`FEPCS_SYM_BITS - 1));
        txReady = 1'b0;
        txState_next = txState_reg;
        txBit_next = symEnd ? 3'h0 : txBit_reg + 3'h1;
        txSym_next = {txSym_reg[3:0], 1'b0};
        if (symEnd)
        begin
            unique case (txState_reg)
                fepcs_pkg::FEPCS_TX_IDLE, fepcs_pkg::FEPCS_TX_R:
                begin
                    txState_next = txEn ? fepcs_pkg::FEPCS_TX_J : fepcs_pkg::FEPCS_TX_IDLE;
                    txSym_next = txEn ? `FEPCS_CODE_J : `FEPCS_CODE_I;
                end
                fepcs_pkg::FEPCS_TX_J:
                begin
                    txState_next = fepcs_pkg::FEPCS_TX_K;
                    txSym_next = `FEPCS_CODE_K;
                end
                fepcs_pkg::FEPCS_TX_K, fepcs_pkg::FEPCS_TX_DATA:
                begin
                    txState_next = txEn ? fepcs_pkg::FEPCS_TX_DATA : fepcs_pkg::FEPCS_TX_T;
                    txSym_next = !txEn ? `FEPCS_CODE_T : (txEr ? `FEPCS_CODE_H : enc4b5b(txData));
                    txReady = clkEn && txEn;
                end
                fepcs_pkg::FEPCS_TX_T:
                begin
                    txState_next = fepcs_pkg::FEPCS_TX_R;
                    txSym_next = `FEPCS_CODE_R;
                end
                default:
                begin
                    txState_next = fepcs_pkg::FEPCS_TX_IDLE;
                    txSym_next = `FEPCS_CODE_I;
                end
            endcase
        end
        // Fault pattern only replaces idle, never a frame
        faultCnt_next = (faultCnt_reg == 7'(`FEPCS_FAULT_ONES)) ? 7'h00 : faultCnt_reg + 7'h01;
        codeBit = (faultActive && txState_reg == fepcs_pkg::FEPCS_TX_IDLE)
            ? (faultCnt_reg != 7'(`FEPCS_FAULT_ONES)) : txSym_reg[4];
        scr_next = {scr_reg[9:0], scrKey(scr_reg)};
        lineBit = fiberMode ? codeBit : (codeBit ^ scrKey(scr_reg));
        nrzi_next = nrzi_reg ^ lineBit;
        mlt3Phase_next = mlt3Phase_reg + {1'b0, lineBit};
        txLine_next.nrzi = nrzi_next;
        if (fiberMode)
            txLine_next.level = nrzi_next ? fepcs_pkg::FEPCS_LVL_PLUS : fepcs_pkg::FEPCS_LVL_ZERO;
        else if (mlt3Phase_next == 2'h1)
            txLine_next.level = fepcs_pkg::FEPCS_LVL_PLUS;
        else if (mlt3Phase_next == 2'h3)
            txLine_next.level = fepcs_pkg::FEPCS_LVL_MINUS;
        else
            txLine_next.level = fepcs_pkg::FEPCS_LVL_ZERO;
    end

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            txState_reg <= fepcs_pkg::FEPCS_TX_IDLE;
            txSym_reg <= `FEPCS_CODE_I;
            txBit_reg <= 3'h0;
            scr_reg <= `FEPCS_SCR_SEED;
            faultCnt_reg <= 7'h00;
            nrzi_reg <= 1'b0;
            mlt3Phase_reg <= 2'h0;
            txLine_reg <= '0;
        end
        else if (clkEn)
        begin
            txState_reg <= txState_next;
            txSym_reg <= txSym_next;
            txBit_reg <= txBit_next;
            scr_reg <= scr_next;
            faultCnt_reg <= faultCnt_next;
            nrzi_reg <= nrzi_next;
            mlt3Phase_reg <= mlt3Phase_next;
            txLine_reg <= txLine_next;
        end
    end

    assign txLine = txLine_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Receive
    fepcs_pkg::fepcs_rx_state_e rxState_reg, rxState_next;
    logic [1:0] rxLvlPrev_reg, rxLvlPrev_next;
    logic rxNrzi_reg, rxNrzi_next;
    logic [5:0] runCnt_reg, runCnt_next;
    logic [10:0] dscr_reg, dscr_next;
    logic [5:0] idleRun_reg, idleRun_next;
    logic dscrLock_reg, dscrLock_next;
    logic [9:0] rxWin_reg, rxWin_next;
    logic [2:0] rxBit_reg, rxBit_next;
    fepcs_pkg::fepcs_mii_rx_s rxMii_reg, rxMii_next;
    logic rxValid_reg, rxValid_next;
    logic nrzBit, plainBit, bitClkOk, synced;
    logic [4:0] rxDec;

    always_comb
    begin
        rxLvlPrev_next = rxLine.level;
        // Any level step is one NRZI transition; fiber takes NRZI directly
        rxNrzi_next = fiberMode ? rxLine.nrzi : (rxNrzi_reg ^ (rxLine.level != rxLvlPrev_reg));
        nrzBit = rxNrzi_next ^ rxNrzi_reg;
        // Transition density stands in for the recovered clock being alive
        runCnt_next = nrzBit ? 6'h00 : (runCnt_reg == 6'h3F ? runCnt_reg : runCnt_reg + 6'h01);
        bitClkOk = (runCnt_reg < 6'(`FEPCS_RUN_LIMIT));
        // Unlocked: assume idle ones, so the key is the inverted line bit
        plainBit = fiberMode ? nrzBit : (nrzBit ^ scrKey(dscr_reg));
        dscr_next = {dscr_reg[9:0], dscrLock_reg ? scrKey(dscr_reg) : ~nrzBit};
        idleRun_next = !plainBit ? 6'h00 : (idleRun_reg == 6'h3F ? idleRun_reg : idleRun_reg + 6'h01);
        dscrLock_next = bitClkOk && (dscrLock_reg || idleRun_reg >= 6'(`FEPCS_DESCR_LOCK_RUN));
        synced = fiberMode ? bitClkOk : dscrLock_reg;
        rxWin_next = {rxWin_reg[8:0], plainBit};
        rxBit_next = (rxBit_reg == 3'(`FEPCS_SYM_BITS - 1)) ? 3'h0 : rxBit_reg + 3'h1;
        rxDec = dec5b4b(rxWin_next[4:0]);
        rxState_next = rxState_reg;
        rxMii_next = rxMii_reg;
        rxValid_next = 1'b0;
        if (!synced)
        begin
            rxState_next = fepcs_pkg::FEPCS_RX_HUNT;
            rxMii_next = '0;
        end
        else
        begin
            unique case (rxState_reg)
                fepcs_pkg::FEPCS_RX_HUNT:
                begin
                    if (rxWin_next == {`FEPCS_CODE_J, `FEPCS_CODE_K})
                    begin
                        rxState_next = fepcs_pkg::FEPCS_RX_DATA;
                        rxBit_next = 3'h0;
                    end
                end
                fepcs_pkg::FEPCS_RX_DATA:
                begin
                    if (rxBit_reg == 3'(`FEPCS_SYM_BITS - 1))
                    begin
                        if (rxWin_next[4:0] == `FEPCS_CODE_T || rxWin_next[4:0] == `FEPCS_CODE_I)
                        begin
                            // Idle without T is a cut-short frame
                            rxState_next = fepcs_pkg::FEPCS_RX_HUNT;
                            rxMii_next.dv = 1'b0;
                            rxMii_next.er = (rxWin_next[4:0] == `FEPCS_CODE_I);
                        end
                        else
                        begin
                            rxMii_next.dv = 1'b1;
                            rxMii_next.er = !rxDec[4];
                            rxMii_next.data = rxDec[3:0];
                        end
                        rxValid_next = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            rxState_reg <= fepcs_pkg::FEPCS_RX_HUNT;
            rxLvlPrev_reg <= 2'h0;
            rxNrzi_reg <= 1'b0;
            runCnt_reg <= 6'h3F;
            dscr_reg <= `FEPCS_SCR_SEED;
            idleRun_reg <= 6'h00;
            dscrLock_reg <= 1'b0;
            rxWin_reg <= 10'h000;
            rxBit_reg <= 3'h0;
            rxMii_reg <= '0;
            rxValid_reg <= 1'b0;
        end
        else if (clkEn)
        begin
            rxState_reg <= rxState_next;
            rxLvlPrev_reg <= rxLvlPrev_next;
            rxNrzi_reg <= rxNrzi_next;
            runCnt_reg <= runCnt_next;
            dscr_reg <= dscr_next;
            idleRun_reg <= idleRun_next;
            dscrLock_reg <= dscrLock_next;
            rxWin_reg <= rxWin_next;
            rxBit_reg <= rxBit_next;
            rxMii_reg <= rxMii_next;
            rxValid_reg <= rxValid_next;
        end
    end

    assign rxMii = rxMii_reg;
    assign rxValid = rxValid_reg && clkEn;
    assign rxLocked = fiberMode ? bitClkOk : dscrLock_reg;

endmodule

// File: verif/fepcs_link_partner.sv
// Link partner: echoes the port's own line back, and models the optical module.
// Assumes one line sample per core_clk edge; dark fiber carries no transitions.
module fepcs_link_partner (
    // Clock
    input wire logic core_clk,
    // Line
    input wire fepcs_pkg::fepcs_line_s txLine,
    output fepcs_pkg::fepcs_line_s rxLine,
    // Optical module
    input wire logic lightOn,
    output logic signalDetect
);
    timeunit 1ns;
    timeprecision 1ps;

    assign signalDetect = lightOn;
    // Echo keeps the transmitter's own scrambler sequence on the receive side
    always_ff @(posedge core_clk)
    begin
        rxLine <= lightOn ? txLine : 3'h0;
    end
endmodule

// File: verif/fepcs_tx_fx_checker.sv
// Port assertions for the fast ethernet coding path, bound into fepcs_tx_fx.
// Assumes clkEn is held high, so every core_clk edge is one line bit time.
module fepcs_tx_fx_checker #(
    parameter int PORT_NUM = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstN,
    // MII side
    input wire logic txEn,
    input wire logic txReady,
    input wire fepcs_pkg::fepcs_mii_rx_s rxMii,
    input wire logic rxValid,
    // Line and mode
    input wire fepcs_pkg::fepcs_line_s txLine,
    input wire logic fiberModeSense,
    input wire logic fiberSignalDetect,
    input wire logic farEndFaultEn,
    input wire logic fiberMode,
    input wire logic autoNegEnable,
    // Timing
    input wire fepcs_pkg::fepcs_ticks_s clkTicks,
    input wire logic refLocked
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking

    ////////////////////////////////////////////////////////////////////////////////
    // Run of NRZ ones on the line; age keeps earlier idle runs out of the check
    logic prevReg, prevNext;
    logic [7:0] runReg, runNext, ageReg, ageNext;
    logic faultIdle;
    assign faultIdle = fiberMode && !fiberSignalDetect && farEndFaultEn && !txEn;
    always_comb
    begin
        prevNext = txLine.nrzi;
        runNext = 8'h00;
        ageNext = 8'h00;
        if (txLine.nrzi != prevReg)
        begin
            runNext = (runReg == 8'hFF) ? runReg : runReg + 8'h01;
        end
        if (faultIdle)
        begin
            ageNext = (ageReg == 8'hFF) ? ageReg : ageReg + 8'h01;
        end
    end
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            prevReg <= 1'b0;
            runReg <= 8'h00;
            ageReg <= 8'h00;
        end
        else
        begin
            prevReg <= prevNext;
            runReg <= runNext;
            ageReg <= ageNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_reset_quiet: assert property (!rstN |-> txLine == 3'h0 && rxMii == 6'h00 && !rxValid && !txReady)
        else $error("outputs not quiet in reset");
    a_autoneg_off: assert property (disable iff (!rstN) autoNegEnable == !fiberMode)
        else $error("auto-negotiation not tied to fiber mode");
    a_fiber_select: assert property (disable iff (!rstN) fiberMode == ((PORT_NUM == 4 || PORT_NUM == 5) && fiberModeSense))
        else $error("fiber mode selection wrong");
    a_fiber_no_mlt3: assert property (disable iff (!rstN) fiberMode && $past(fiberMode) && $past(fiberMode, 2)
        |-> txLine.level == (txLine.nrzi ? fepcs_pkg::FEPCS_LVL_PLUS : fepcs_pkg::FEPCS_LVL_ZERO))
        else $error("fiber line level not plain NRZI");
    a_mlt3_step: assert property (disable iff (!rstN) !fiberMode && !$past(fiberMode) && !$past(fiberMode, 2)
        && $past(rstN) |-> (txLine.nrzi != $past(txLine.nrzi)) == (txLine.level != $past(txLine.level)))
        else $error("MLT3 level step not tied to NRZI toggle");
    a_mlt3_via_zero: assert property (disable iff (!rstN) !fiberMode && !$past(fiberMode) && $past(rstN)
        && !$past(fiberMode, 2) && $past(txLine.level) != fepcs_pkg::FEPCS_LVL_ZERO && $changed(txLine.level)
        |-> txLine.level == fepcs_pkg::FEPCS_LVL_ZERO)
        else $error("MLT3 skipped the zero level");
    a_tx_nibble_gap: assert property (disable iff (!rstN) txReady |=> !txReady [*4])
        else $error("nibbles taken closer than five bits");
    a_rx_nibble_gap: assert property (disable iff (!rstN) rxValid |=> !rxValid [*4])
        else $error("receive nibbles closer than five bits");
    a_tick25_period: assert property (disable iff (!rstN) refLocked && clkTicks.tick25 |-> ##5 clkTicks.tick25)
        else $error("25 MHz tick not every five bits");
    a_fault_run: assert property (disable iff (!rstN) ageReg >= 8'h60 |-> runReg <= 8'h54)
        else $error("far-end fault run longer than 84 ones");
endmodule

bind fepcs_tx_fx fepcs_tx_fx_checker #(.PORT_NUM(PORT_NUM)) u_fepcs_tx_fx_checker (
    .core_clk(core_clk), .rstN(rstN), .txEn(txEn), .txReady(txReady), .rxMii(rxMii), .rxValid(rxValid),
    .txLine(txLine), .fiberModeSense(fiberModeSense), .fiberSignalDetect(fiberSignalDetect),
    .farEndFaultEn(farEndFaultEn), .fiberMode(fiberMode), .autoNegEnable(autoNegEnable),
    .clkTicks(clkTicks), .refLocked(refLocked));

// File: verif/fepcs_tx_fx_tb.sv
// Self-checking bench for fepcs_tx_fx with a looped-back link partner.
// Assumes clkEn held high and a reference edge every five bits.
module fepcs_tx_fx_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [4:0] CODES [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic core_clk, rstN, clkEn, referenceClockIn, txEn, txEr, txReady, rxValid, lightOn;
    logic fiberModeSense, fiberSignalDetect, farEndFaultEn, fiberMode, autoNegEnable, rxLocked, refLocked;
    logic [3:0] txData;
    logic [2:0] refCnt;
    logic prevNrzi, gotJk;
    logic [14:0] lineBits;
    logic [4:0] codeAfterJk;
    logic [3:0] rxQ[$];
    fepcs_pkg::fepcs_mii_rx_s rxMii;
    fepcs_pkg::fepcs_line_s txLine, rxLine;
    fepcs_pkg::fepcs_ticks_s clkTicks;
    int nErrors = 0;
    int checkCount = 0;

    fepcs_tx_fx #(.PORT_NUM(4)) u_fepcs_tx_fx (.core_clk(core_clk), .rstN(rstN), .clkEn(clkEn),
        .referenceClockIn(referenceClockIn), .txEn(txEn), .txEr(txEr), .txData(txData), .txReady(txReady),
        .rxMii(rxMii), .rxValid(rxValid), .txLine(txLine), .rxLine(rxLine), .fiberModeSense(fiberModeSense),
        .fiberSignalDetect(fiberSignalDetect), .farEndFaultEn(farEndFaultEn), .fiberMode(fiberMode),
        .autoNegEnable(autoNegEnable), .rxLocked(rxLocked), .clkTicks(clkTicks), .refLocked(refLocked));
    fepcs_link_partner u_fepcs_link_partner (.core_clk(core_clk), .txLine(txLine), .rxLine(rxLine),
        .lightOn(lightOn), .signalDetect(fiberSignalDetect));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Reference, NRZ view of the line, first group after J/K, received nibbles
    always @(posedge core_clk)
    begin
        refCnt <= (refCnt == 3'h4) ? 3'h0 : refCnt + 3'h1;
        referenceClockIn <= (refCnt < 3'h2);
        prevNrzi <= txLine.nrzi;
        lineBits <= {lineBits[13:0], txLine.nrzi ^ prevNrzi};
        if (lineBits[14:5] == 10'h311 && !gotJk)
        begin
            gotJk <= 1'b1;
            codeAfterJk <= lineBits[4:0];
        end
        if (rxValid === 1'b1 && rxMii.dv === 1'b1)
            rxQ.push_back(rxMii.data);
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic giveVerdict();
        if (nErrors == 0 && checkCount > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checkCount++;
        if (got !== exp)
        begin
            nErrors++;
            $display("[FAIL] %0t %s: got %h, expected %h", $time, what, got, exp);
        end
    endtask

    task automatic waitHigh(ref logic sig, input int lim, input string what);
        int k;
        for (k = 0; k < lim && sig !== 1'b1; k++)
            @(posedge core_clk);
        cmp(32'(sig), 32'h1, what);
        if (sig !== 1'b1)
            giveVerdict();
    endtask

    task automatic doReset();
        rstN <= 1'b0;
        repeat (5) @(posedge core_clk);
        cmp(32'(txLine), 32'h0, "line in reset");
        cmp(32'(refLocked), 32'h0, "lock in reset");
        rstN <= 1'b1;
        waitHigh(refLocked, 60, "reference lock");
    endtask

    // Ticks over 750 bits: 125/3, 125/5 and 125/12.5 give whole counts
    task automatic checkTicks();
        int i, c42, c25, c10;
        c42 = 0;
        c25 = 0;
        c10 = 0;
        for (i = 0; i < 750; i++)
        begin
            @(posedge core_clk);
            c42 += int'(clkTicks.tick42);
            c25 += int'(clkTicks.tick25);
            c10 += int'(clkTicks.tick10);
        end
        cmp(c42, 250, "42 MHz ticks");
        cmp(c25, 150, "25 MHz ticks");
        cmp(c10, 60, "10 MHz ticks");
    endtask

    task automatic checkMode(input logic s);
        fiberModeSense <= s;
        repeat (2) @(posedge core_clk);
        cmp(32'(fiberMode), 32'(s), "fiber mode");
        cmp(32'(autoNegEnable), 32'(!s), "auto-negotiation");
    endtask

    // Idle key = NRZ bit xor 1; must obey x^11+x^9+1 and repeat after 2047
    task automatic checkScrambler();
        bit k[$];
        int i, bad, ones;
        bad = 0;
        ones = 0;
        for (i = 0; i < 2100; i++)
        begin
            @(posedge core_clk);
            k.push_back(lineBits[0] ^ 1'b1);
            if (i >= 11 && k[i] != (k[i - 9] ^ k[i - 11]))
                bad++;
            if (i >= 2047 && k[i] != k[i - 2047])
                bad++;
            if (i < 2047)
                ones += int'(k[i]);
        end
        cmp(bad, 0, "scrambler sequence");
        cmp(ones, 1024, "scrambler ones per period");
    endtask

    task automatic sendFrame(input int n);
        int i, k;
        rxQ.delete();
        gotJk <= 1'b0;
        txEn <= 1'b1;
        txData <= 4'h0;
        for (i = 0, k = 0; i < n && k < 400; k++)
        begin
            @(posedge core_clk);
            if (txReady === 1'b1)
            begin
                i++;
                txData <= i[3:0];
                if (i == n)
                    txEn <= 1'b0;
            end
        end
        for (k = 0; k < 200 && rxQ.size() < n; k++)
            @(posedge core_clk);
        cmp(rxQ.size(), n, "nibbles received");
        for (i = 0; i < rxQ.size(); i++)
            cmp(32'(rxQ[i]), 32'(i[3:0]), "nibble value");
        repeat (30) @(posedge core_clk);
    endtask

    task automatic countRun(output int ones);
        int k;
        for (k = 0; k < 300 && lineBits[0] !== 1'b0; k++)
            @(posedge core_clk);
        ones = 0;
        for (k = 0; k < 300 && lineBits[0] !== 1'b1; k++)
            @(posedge core_clk);
        for (k = 0; k < 300 && lineBits[0] === 1'b1; k++)
        begin
            ones++;
            @(posedge core_clk);
        end
    endtask

    task automatic checkFault();
        int n;
        lightOn <= 1'b0;
        farEndFaultEn <= 1'b1;
        countRun(n);
        countRun(n);
        cmp(n, 84, "fault run of ones");
        cmp(32'(rxLocked), 32'h0, "lock on dark fiber");
        farEndFaultEn <= 1'b0;
        countRun(n);
        cmp(n, 300, "fault pattern disabled");
        farEndFaultEn <= 1'b1;
        lightOn <= 1'b1;
        countRun(n);
        cmp(n, 300, "no fault with signal present");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (60000) @(posedge core_clk);
        cmp(32'h0, 32'h1, "run time limit");
        giveVerdict();
    end

    initial
    begin
        rstN = 1'b0;
        clkEn = 1'b1;
        referenceClockIn = 1'b0;
        refCnt = 3'h0;
        txEn = 1'b0;
        txEr = 1'b0;
        txData = 4'h0;
        fiberModeSense = 1'b0;
        farEndFaultEn = 1'b0;
        lightOn = 1'b1;
        gotJk = 1'b0;
        doReset();
        checkTicks();
        checkMode(1'b1);
        checkMode(1'b0);
        waitHigh(rxLocked, 600, "copper lock");
        checkScrambler();
        sendFrame(16);
        // Second reset mid-run, then the same frame over fiber
        doReset();
        checkMode(1'b1);
        waitHigh(rxLocked, 200, "fiber lock");
        sendFrame(16);
        cmp(32'(codeAfterJk), 32'(CODES[0]), "first code group after J/K");
        checkFault();
        giveVerdict();
    end
endmodule
